/* include/dtcu_pkg.sv */
// Constants, modes and carriers shared by the dual timer/counter unit
package dtcu_pkg;

  // ----------------------------------------------------------------
  // Special-function register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] DTCU_ADDR_PWR = 8'h87;
  localparam logic [7:0] DTCU_ADDR_CTRL = 8'h88;
  localparam logic [7:0] DTCU_ADDR_MODE = 8'h89;
  localparam logic [7:0] DTCU_ADDR_ZERO_LO = 8'h8A;
  localparam logic [7:0] DTCU_ADDR_ONE_LO = 8'h8B;
  localparam logic [7:0] DTCU_ADDR_ZERO_HI = 8'h8C;
  localparam logic [7:0] DTCU_ADDR_ONE_HI = 8'h8D;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DTCU_CTRL_FLAG1 = 7;
  localparam int DTCU_CTRL_RUN1 = 6;
  localparam int DTCU_CTRL_FLAG0 = 5;
  localparam int DTCU_CTRL_RUN0 = 4;
  localparam int DTCU_MODE_GATE1 = 7;
  localparam int DTCU_MODE_SEL1 = 6;
  localparam int DTCU_MODE_FIELD1 = 4;
  localparam int DTCU_MODE_GATE0 = 3;
  localparam int DTCU_MODE_SEL0 = 2;
  localparam int DTCU_MODE_FIELD0 = 0;
  localparam int DTCU_PWR_BAUD = 7;
  localparam int DTCU_PWR_STOP = 1;
  localparam int DTCU_PWR_IDLE = 0;

  // ----------------------------------------------------------------
  // Reset values, masks and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] DTCU_RST_BYTE = 8'h00;
  localparam logic [7:0] DTCU_PWR_USED = 8'h83;
  localparam logic DTCU_PIN_IDLE = 1'b1;
  localparam int DTCU_CLK_MHZ = 125;
  localparam int DTCU_MC_DIV = 12;
  localparam logic [3:0] DTCU_MC_LAST = 4'(DTCU_MC_DIV - 1);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DTCU_MODE_13BIT,
    DTCU_MODE_16BIT,
    DTCU_MODE_RELOAD,
    DTCU_MODE_SPLIT
  } dtcu_mode_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dtcu_sfr_req_s;

  typedef struct packed {
    logic ovf;
    logic [7:0] hi;
    logic [7:0] lo;
  } dtcu_cnt_s;

endpackage

/* hdl/dtcu_edge_det.sv */
// Synchroniser and machine-cycle falling-edge detector for one input
module dtcu_edge_det (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Input and machine-cycle strobe
  input wire logic pin_in,
  input wire logic tick,
  // Edge event, valid in the tick cycle
  output logic fall
);

  logic sync1_q;
  logic sync2_q;
  logic samp_q;

  // ----------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= dtcu_pkg::DTCU_PIN_IDLE;
      sync2_q <= dtcu_pkg::DTCU_PIN_IDLE;
    end
    else
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Sample once per machine cycle
  // ----------------------------------------------------------------
  // Levels shorter than a machine cycle may be missed
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      samp_q <= dtcu_pkg::DTCU_PIN_IDLE;
    else if (tick)
      samp_q <= sync2_q;
  end

  // High in one sample, low in the next: two machine cycles
  assign fall = tick & samp_q & ~sync2_q;

endmodule

/* hdl/dtcu_top.sv */
// Dual 16-bit timer/counter unit with power-control register
module dtcu_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Special-function register access
  input wire dtcu_pkg::dtcu_sfr_req_s sfr_req,
  output logic [7:0] sfr_rdata_q,
  // Gating inputs and interrupt-source signals, asynchronous
  input wire logic [1:0] gating_in,
  input wire logic [1:0] gate_src,
  // Interrupt handshake from the core
  input wire logic [1:0] ovf_irq_ack,
  input wire logic ext_irq,
  input wire logic int_irq,
  // Status
  output logic timer_zero_overflow_flag_q,
  output logic timer_one_overflow_flag_q,
  output logic baud_double_q,
  output logic periph_halt_q,
  output logic fetch_halt_q
);

  logic [7:0] timer_zero_low_byte_q;
  logic [7:0] timer_zero_high_byte_q;
  logic [7:0] timer_one_low_byte_q;
  logic [7:0] timer_one_high_byte_q;
  logic [7:0] timer_mode_register_q;
  logic [7:0] power_control_register_q;
  logic [7:0] power_control_register_d;
  logic timer_zero_run_q;
  logic timer_one_run_q;
  logic [3:0] presc_q;
  logic tick;
  logic [3:0] fall;
  logic [3:0] edge_in;
  dtcu_pkg::dtcu_mode_e mode0;
  dtcu_pkg::dtcu_mode_e mode1;
  dtcu_pkg::dtcu_cnt_s step0;
  dtcu_pkg::dtcu_cnt_s step1;
  logic [8:0] split_lo;
  logic [8:0] split_hi;
  logic split0;
  logic ev0;
  logic ev1;
  logic inc0;
  logic inc1;
  logic inc_hi0;
  logic set0;
  logic set1;
  logic wr_ctrl;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic wr_hit(input dtcu_pkg::dtcu_sfr_req_s r,
                                  input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // One counting step for the non-split modes; mode 3 holds
  function automatic dtcu_pkg::dtcu_cnt_s dtcu_step(
    input dtcu_pkg::dtcu_mode_e m, input logic [7:0] hi,
    input logic [7:0] lo);
    dtcu_pkg::dtcu_cnt_s r;
    logic [16:0] s;
    r.ovf = 1'b0;
    r.hi = hi;
    r.lo = lo;
    s = 17'h00000;
    case (m)
      dtcu_pkg::DTCU_MODE_13BIT:
      begin
        s = {4'h0, hi, lo[4:0]} + 17'h00001;
        r.hi = s[12:5];
        r.lo = {3'h0, s[4:0]};
        r.ovf = s[13];
      end
      dtcu_pkg::DTCU_MODE_16BIT:
      begin
        s = {1'b0, hi, lo} + 17'h00001;
        r.hi = s[15:8];
        r.lo = s[7:0];
        r.ovf = s[16];
      end
      dtcu_pkg::DTCU_MODE_RELOAD:
      begin
        s = {9'h000, lo} + 17'h00001;
        r.ovf = s[8];
        r.lo = s[8] ? hi : s[7:0];
      end
      default:
      begin
        r.ovf = 1'b0;
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Machine-cycle prescaler
  // ----------------------------------------------------------------
  // Frozen while the stop bit is set
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      presc_q <= 4'h0;
    else if (!power_control_register_q[dtcu_pkg::DTCU_PWR_STOP])
      presc_q <= tick ? 4'h0 : presc_q + 4'h1;
  end

  assign tick = (presc_q == dtcu_pkg::DTCU_MC_LAST) &&
                !power_control_register_q[dtcu_pkg::DTCU_PWR_STOP];

  // ----------------------------------------------------------------
  // Edge detectors: gating inputs then interrupt sources
  // ----------------------------------------------------------------
  assign edge_in = {gate_src, gating_in};

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_edge
      dtcu_edge_det u_edge (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_in(edge_in[g]),
        .tick(tick),
        .fall(fall[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Count decisions
  // ----------------------------------------------------------------
  assign mode0 = dtcu_pkg::dtcu_mode_e'(
    timer_mode_register_q[dtcu_pkg::DTCU_MODE_FIELD0 +: 2]);
  assign mode1 = dtcu_pkg::dtcu_mode_e'(
    timer_mode_register_q[dtcu_pkg::DTCU_MODE_FIELD1 +: 2]);
  assign split0 = (mode0 == dtcu_pkg::DTCU_MODE_SPLIT);

  // Gate picks the interrupt source, select picks the pin
  assign ev0 = timer_mode_register_q[dtcu_pkg::DTCU_MODE_GATE0] ? fall[2] :
    (timer_mode_register_q[dtcu_pkg::DTCU_MODE_SEL0] ? fall[0] :
    1'b1);
  assign ev1 = timer_mode_register_q[dtcu_pkg::DTCU_MODE_GATE1] ? fall[3] :
    (timer_mode_register_q[dtcu_pkg::DTCU_MODE_SEL1] ? fall[1] :
    1'b1);

  assign inc0 = tick & timer_zero_run_q & ev0;
  assign inc1 = tick & timer_one_run_q & ev1;
  assign inc_hi0 = tick & timer_one_run_q;

  assign step0 = dtcu_step(mode0, timer_zero_high_byte_q,
                           timer_zero_low_byte_q);
  assign step1 = dtcu_step(mode1, timer_one_high_byte_q,
                           timer_one_low_byte_q);
  assign split_lo = {1'b0, timer_zero_low_byte_q} + 9'h001;
  assign split_hi = {1'b0, timer_zero_high_byte_q} + 9'h001;

  assign set0 = split0 ? (inc0 & split_lo[8]) : (inc0 & step0.ovf);
  assign set1 = split0 ? (inc_hi0 & split_hi[8]) :
                (inc1 & step1.ovf);
  assign wr_ctrl = wr_hit(sfr_req, dtcu_pkg::DTCU_ADDR_CTRL);

  // ----------------------------------------------------------------
  // Timer 0 counter bytes
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      timer_zero_low_byte_q <= dtcu_pkg::DTCU_RST_BYTE;
      timer_zero_high_byte_q <= dtcu_pkg::DTCU_RST_BYTE;
    end
    else
    begin
      if (wr_hit(sfr_req, dtcu_pkg::DTCU_ADDR_ZERO_LO))
        timer_zero_low_byte_q <= (mode0 == dtcu_pkg::DTCU_MODE_13BIT) ?
          {3'h0, sfr_req.wdata[4:0]} : sfr_req.wdata;
      else if (inc0)
        timer_zero_low_byte_q <= split0 ? split_lo[7:0] : step0.lo;
      if (wr_hit(sfr_req, dtcu_pkg::DTCU_ADDR_ZERO_HI))
        timer_zero_high_byte_q <= sfr_req.wdata;
      else if (split0 ? inc_hi0 : inc0)
        timer_zero_high_byte_q <= split0 ? split_hi[7:0] : step0.hi;
    end
  end

  // ----------------------------------------------------------------
  // Timer 1 counter bytes
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      timer_one_low_byte_q <= dtcu_pkg::DTCU_RST_BYTE;
      timer_one_high_byte_q <= dtcu_pkg::DTCU_RST_BYTE;
    end
    else
    begin
      if (wr_hit(sfr_req, dtcu_pkg::DTCU_ADDR_ONE_LO))
        timer_one_low_byte_q <= (mode1 == dtcu_pkg::DTCU_MODE_13BIT) ?
          {3'h0, sfr_req.wdata[4:0]} : sfr_req.wdata;
      else if (inc1)
        timer_one_low_byte_q <= step1.lo;
      if (wr_hit(sfr_req, dtcu_pkg::DTCU_ADDR_ONE_HI))
        timer_one_high_byte_q <= sfr_req.wdata;
      else if (inc1)
        timer_one_high_byte_q <= step1.hi;
    end
  end

  // ----------------------------------------------------------------
  // Mode and control registers, overflow flags
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      timer_mode_register_q <= dtcu_pkg::DTCU_RST_BYTE;
    else if (wr_hit(sfr_req, dtcu_pkg::DTCU_ADDR_MODE))
      timer_mode_register_q <= sfr_req.wdata;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      timer_zero_run_q <= 1'b0;
      timer_one_run_q <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      timer_zero_run_q <= sfr_req.wdata[dtcu_pkg::DTCU_CTRL_RUN0];
      timer_one_run_q <= sfr_req.wdata[dtcu_pkg::DTCU_CTRL_RUN1];
    end
  end

  // A hardware set wins over a write or a service clear
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      timer_zero_overflow_flag_q <= 1'b0;
      timer_one_overflow_flag_q <= 1'b0;
    end
    else
    begin
      timer_zero_overflow_flag_q <= set0 | (wr_ctrl ?
        sfr_req.wdata[dtcu_pkg::DTCU_CTRL_FLAG0] :
        (!ovf_irq_ack[0] & timer_zero_overflow_flag_q));
      timer_one_overflow_flag_q <= set1 | (wr_ctrl ?
        sfr_req.wdata[dtcu_pkg::DTCU_CTRL_FLAG1] :
        (!ovf_irq_ack[1] & timer_one_overflow_flag_q));
    end
  end

  // ----------------------------------------------------------------
  // Power control register
  // ----------------------------------------------------------------
  always_comb
  begin
    power_control_register_d = power_control_register_q;
    if (wr_hit(sfr_req, dtcu_pkg::DTCU_ADDR_PWR))
      power_control_register_d = sfr_req.wdata &
                                 dtcu_pkg::DTCU_PWR_USED;
    else
    begin
      if (ext_irq)
        power_control_register_d[dtcu_pkg::DTCU_PWR_STOP] = 1'b0;
      if (int_irq)
        power_control_register_d[dtcu_pkg::DTCU_PWR_IDLE] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      power_control_register_q <= dtcu_pkg::DTCU_RST_BYTE;
      baud_double_q <= 1'b0;
      periph_halt_q <= 1'b0;
      fetch_halt_q <= 1'b0;
    end
    else
    begin
      power_control_register_q <= power_control_register_d;
      baud_double_q <= power_control_register_d[dtcu_pkg::DTCU_PWR_BAUD];
      periph_halt_q <= power_control_register_d[dtcu_pkg::DTCU_PWR_STOP];
      fetch_halt_q <= power_control_register_d[dtcu_pkg::DTCU_PWR_STOP] |
        power_control_register_d[dtcu_pkg::DTCU_PWR_IDLE];
    end
  end

  // ----------------------------------------------------------------
  // Read data, one cycle after the read strobe
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      sfr_rdata_q <= dtcu_pkg::DTCU_RST_BYTE;
    else if (sfr_req.rd)
    begin
      if (sfr_req.addr == dtcu_pkg::DTCU_ADDR_PWR)
        sfr_rdata_q <= power_control_register_q;
      else if (sfr_req.addr == dtcu_pkg::DTCU_ADDR_CTRL)
        sfr_rdata_q <= {timer_one_overflow_flag_q, timer_one_run_q,
                        timer_zero_overflow_flag_q, timer_zero_run_q, 4'h0};
      else if (sfr_req.addr == dtcu_pkg::DTCU_ADDR_MODE)
        sfr_rdata_q <= timer_mode_register_q;
      else if (sfr_req.addr == dtcu_pkg::DTCU_ADDR_ZERO_LO)
        sfr_rdata_q <= timer_zero_low_byte_q;
      else if (sfr_req.addr == dtcu_pkg::DTCU_ADDR_ONE_LO)
        sfr_rdata_q <= timer_one_low_byte_q;
      else if (sfr_req.addr == dtcu_pkg::DTCU_ADDR_ZERO_HI)
        sfr_rdata_q <= timer_zero_high_byte_q;
      else if (sfr_req.addr == dtcu_pkg::DTCU_ADDR_ONE_HI)
        sfr_rdata_q <= timer_one_high_byte_q;
      else
        sfr_rdata_q <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_mc_gap;
    tick |=> !tick [*8];
  endproperty
  a_mc_gap: assert property (p_mc_gap)
    else $error("machine tick repeated too soon");

  property p_mode1_wrap;
    (mode0 == dtcu_pkg::DTCU_MODE_16BIT && inc0 && !sfr_req.wr &&
     (&{timer_zero_high_byte_q, timer_zero_low_byte_q})) |=>
    ({timer_zero_high_byte_q, timer_zero_low_byte_q} == 16'h0000 &&
     timer_zero_overflow_flag_q);
  endproperty
  a_mode1_wrap: assert property (p_mode1_wrap)
    else $error("16-bit wrap or flag wrong");

  property p_reload;
    (mode0 == dtcu_pkg::DTCU_MODE_RELOAD && inc0 && !sfr_req.wr &&
     (&timer_zero_low_byte_q)) |=>
    timer_zero_low_byte_q == $past(timer_zero_high_byte_q);
  endproperty
  a_reload: assert property (p_reload)
    else $error("auto-reload value not copied");

  property p_mode0_top;
    (mode0 == dtcu_pkg::DTCU_MODE_13BIT && inc0 && !sfr_req.wr) |=>
    timer_zero_low_byte_q[7:5] == 3'h0;
  endproperty
  a_mode0_top: assert property (p_mode0_top)
    else $error("13-bit mode upper low bits not zero");

  property p_one_halt;
    (mode1 == dtcu_pkg::DTCU_MODE_SPLIT && !sfr_req.wr) |=>
    $stable({timer_one_high_byte_q, timer_one_low_byte_q});
  endproperty
  a_one_halt: assert property (p_one_halt)
    else $error("timer one moved in mode 3");

  property p_run_off;
    (!timer_zero_run_q && !split0 && !sfr_req.wr) |=>
    $stable({timer_zero_high_byte_q, timer_zero_low_byte_q});
  endproperty
  a_run_off: assert property (p_run_off)
    else $error("timer zero moved while not running");

  property p_stop_freeze;
    (power_control_register_q[dtcu_pkg::DTCU_PWR_STOP] && !sfr_req.wr) |=>
    $stable({timer_zero_high_byte_q, timer_zero_low_byte_q,
             timer_one_high_byte_q, timer_one_low_byte_q});
  endproperty
  a_stop_freeze: assert property (p_stop_freeze)
    else $error("timers moved while stopped");

  property p_flag_set;
    set0 |=> timer_zero_overflow_flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("overflow lost its flag");

  property p_split_hi;
    (split0 && inc_hi0 && !sfr_req.wr && (&timer_zero_high_byte_q)) |=>
    (timer_zero_high_byte_q == 8'h00 && timer_one_overflow_flag_q);
  endproperty
  a_split_hi: assert property (p_split_hi)
    else $error("split high byte overflow wrong");

  property p_baud;
    (sfr_req.wr && sfr_req.addr == dtcu_pkg::DTCU_ADDR_PWR) |=>
    (baud_double_q == $past(sfr_req.wdata[dtcu_pkg::DTCU_PWR_BAUD]) &&
     power_control_register_q[6:2] == 5'h00);
  endproperty
  a_baud: assert property (p_baud)
    else $error("baud doubling bit wrong");

  property p_gate_edge;
    (timer_mode_register_q[dtcu_pkg::DTCU_MODE_GATE0] && !fall[2] &&
     !sfr_req.wr) |=> $stable(timer_zero_low_byte_q);
  endproperty
  a_gate_edge: assert property (p_gate_edge)
    else $error("gated timer counted without source edge");

endmodule

/* verification/testbench.sv */
// Self-checking testbench for the dual timer/counter unit
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [7:0] a_pwr = dtcu_pkg::DTCU_ADDR_PWR;
  localparam logic [7:0] a_ctrl = dtcu_pkg::DTCU_ADDR_CTRL;
  localparam logic [7:0] a_mode = dtcu_pkg::DTCU_ADDR_MODE;
  localparam logic [7:0] a_lo0 = dtcu_pkg::DTCU_ADDR_ZERO_LO;
  localparam logic [7:0] a_hi0 = dtcu_pkg::DTCU_ADDR_ZERO_HI;
  localparam logic [7:0] a_lo1 = dtcu_pkg::DTCU_ADDR_ONE_LO;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  dtcu_pkg::dtcu_sfr_req_s sfr_req = '0;
  logic [7:0] sfr_rdata_q;
  logic [1:0] gating_in = 2'b11;
  logic [1:0] gate_src = 2'b11;
  logic [1:0] ovf_irq_ack = 2'b00;
  logic ext_irq = 1'b0;
  logic int_irq = 1'b0;
  logic flag0;
  logic flag1;
  logic baud;
  logic phalt;
  logic fhalt;
  logic [7:0] stat;
  logic [7:0] v1;
  logic [7:0] v2;
  int err_total = 0;
  int total_checks = 0;

  assign stat = {3'h0, baud, phalt, fhalt, flag1, flag0};

  always #4 ref_clk = ~ref_clk;

  dtcu_top dtcu_top_inst (
    .ref_clk(ref_clk),
    .rst(rst),
    .sfr_req(sfr_req),
    .sfr_rdata_q(sfr_rdata_q),
    .gating_in(gating_in),
    .gate_src(gate_src),
    .ovf_irq_ack(ovf_irq_ack),
    .ext_irq(ext_irq),
    .int_irq(int_irq),
    .timer_zero_overflow_flag_q(flag0),
    .timer_one_overflow_flag_q(flag1),
    .baud_double_q(baud),
    .periph_halt_q(phalt),
    .fetch_halt_q(fhalt)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req <= {a, d, 2'b10};
    @(posedge ref_clk);
    sfr_req <= '0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    sfr_req <= {a, 8'h00, 2'b01};
    @(posedge ref_clk);
    sfr_req <= '0;
    @(posedge ref_clk);
    v = sfr_rdata_q;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask

  // Bits: overflow acks, internal, external interrupt
  task automatic pulse(input logic [3:0] m);
    {ovf_irq_ack, int_irq, ext_irq} <= m;
    @(posedge ref_clk);
    {ovf_irq_ack, int_irq, ext_irq} <= 4'h0;
    @(posedge ref_clk);
  endtask

  task automatic wait_ovf(input logic [1:0] m);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge ref_clk);
      if (({flag1, flag0} & m) !== 2'b00)
        break;
    end
  endtask

  // Falling edges at the fastest rate on both timers' inputs
  task automatic edges(input logic src, input int n);
    repeat (n)
    begin
      gating_in <= {2{src}};
      gate_src <= {2{~src}};
      repeat (12) @(posedge ref_clk);
      gating_in <= 2'b11;
      gate_src <= 2'b11;
      repeat (12) @(posedge ref_clk);
    end
  endtask

  task automatic final_report;
    if (err_total == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int a = 135; a <= 141; a++)
      rd_chk(8'(a), 8'h00);
    rd_chk(8'h90, 8'h00);
    wr(a_mode, 8'h11);
    wr(a_ctrl, 8'h50);
    rd(a_lo0, v1);
    repeat (117) @(posedge ref_clk);
    rd(a_lo0, v2);
    chk(v2 - v1, 8'h0A);
    rd_chk(a_lo1, 8'h0A);
    wr(a_pwr, 8'hFF);
    chk(stat, 8'h1C);
    rd_chk(a_pwr, 8'h83);
    rd(a_lo0, v1);
    repeat (117) @(posedge ref_clk);
    rd(a_lo0, v2);
    chk(v2, v1);
    pulse(4'h1);
    chk(stat, 8'h14);
    pulse(4'h2);
    chk(stat, 8'h10);
    rd_chk(a_pwr, 8'h80);
    wr(a_pwr, 8'h00);
    wr(a_ctrl, 8'h00);
    wr(a_hi0, 8'hFF);
    wr(a_lo0, 8'hFF);
    wr(a_ctrl, 8'h10);
    wait_ovf(2'b01);
    chk(stat, 8'h01);
    rd_chk(a_lo0, 8'h00);
    rd_chk(a_hi0, 8'h00);
    wr(a_ctrl, 8'h00);
    chk(stat, 8'h00);
    wr(a_ctrl, 8'hA0);
    pulse(4'h4);
    chk(stat, 8'h02);
    pulse(4'h8);
    chk(stat, 8'h00);
    wr(a_mode, 8'h00);
    wr(a_lo0, 8'hFF);
    rd_chk(a_lo0, 8'h1F);
    wr(a_hi0, 8'hFF);
    wr(a_ctrl, 8'h10);
    wait_ovf(2'b01);
    rd_chk(a_hi0, 8'h00);
    wr(a_ctrl, 8'h00);
    wr(a_mode, 8'h22);
    wr(a_hi0, 8'hA5);
    wr(a_lo0, 8'hFF);
    wr(a_ctrl, 8'h10);
    wait_ovf(2'b01);
    rd_chk(a_lo0, 8'hA5);
    rd_chk(a_hi0, 8'hA5);
    wr(a_ctrl, 8'h00);
    wr(a_mode, 8'h30);
    wr(a_lo1, 8'h10);
    wr(a_ctrl, 8'h40);
    repeat (36) @(posedge ref_clk);
    rd_chk(a_lo1, 8'h10);
    wr(a_ctrl, 8'h00);
    wr(a_mode, 8'h03);
    wr(a_lo0, 8'hFF);
    wr(a_hi0, 8'hFF);
    wr(a_ctrl, 8'h10);
    wait_ovf(2'b11);
    chk(stat, 8'h01);
    rd_chk(a_hi0, 8'hFF);
    wr(a_ctrl, 8'h40);
    wait_ovf(2'b10);
    chk(stat, 8'h02);
    rd_chk(a_lo0, 8'h00);
    wr(a_ctrl, 8'h00);
    wr(a_mode, 8'h55);
    wr(a_lo0, 8'h00);
    wr(a_hi0, 8'h00);
    wr(a_lo1, 8'h00);
    wr(a_ctrl, 8'h50);
    edges(1'b0, 5);
    rd_chk(a_lo0, 8'h05);
    rd_chk(a_lo1, 8'h05);
    wr(a_ctrl, 8'h00);
    wr(a_mode, 8'h99);
    wr(a_lo0, 8'h00);
    wr(a_lo1, 8'h00);
    wr(a_ctrl, 8'h50);
    edges(1'b1, 3);
    rd_chk(a_lo0, 8'h03);
    rd_chk(a_lo1, 8'h03);
    final_report;
  end

  // Watchdog, well beyond the fewer than a thousand cycles the tests need
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    final_report;
  end
endmodule
